//--- pkg/pci_target_pkg.sv
// package: constants, states and helpers of the pci target protocol block
// How it works
// - trdy, stop, devsel and perr are driven high one clock before release.
// - perr only reports write data taken after this target claimed the cycle.
// - dual address command is reserved here and never claimed.
// - once trdy is asserted, trdy, devsel and stop hold until the phase completes.
// - once stop is asserted, stop, trdy and devsel hold until the phase completes.
// - a word moves only on an edge with irdy and trdy both asserted.
// - on reads trdy is asserted only while valid data sits on ad.
// - an i/o access the byte enables cannot fully serve ends in target-abort.
// - reserved commands are never claimed nor decoded as defined ones.
// - config commands need idsel high and ad[1:0] equal to 00.
// - reserved burst ordering disconnects after the first data phase.
// - ad driven by the target is held stable while trdy is asserted.
// - no trdy in the read turnaround cycle after the address phase.
// - trdy, stop and devsel deassert the clock after the last phase.
// - a burst reaching the end of the memory window is disconnected.
// - stop holds until frame is seen high, then drops the next cycle.
// - trdy is deasserted before target-abort is signalled.
// - an asserted stop is never withdrawn to continue the transfer.
// - the first data phase completes or terminates within 16 clocks.
// - devsel leads every other response and holds except for target-abort.
// - special cycles are never claimed nor answered.
// - par is driven one clock after ad starts being driven.
// - par makes the ones over ad, cbe and par an even count.
// - no bus locking; exclusive access sequences get no special care.
package pci_target_pkg;

    // ****************************************************************
    // bus commands
    // ****************************************************************
    localparam logic [3:0] CMD_INTACK  = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_IO_RD   = 4'h2;
    localparam logic [3:0] CMD_IO_WR   = 4'h3;
    localparam logic [3:0] CMD_MEM_RD  = 4'h6;
    localparam logic [3:0] CMD_MEM_WR  = 4'h7;
    localparam logic [3:0] CMD_CFG_RD  = 4'hA;
    localparam logic [3:0] CMD_CFG_WR  = 4'hB;
    localparam logic [3:0] CMD_MEM_RDM = 4'hC;
    localparam logic [3:0] CMD_DUAL    = 4'hD;
    localparam logic [3:0] CMD_MEM_RDL = 4'hE;
    localparam logic [3:0] CMD_MEM_WRI = 4'hF;

    // ****************************************************************
    // address windows and timing
    // ****************************************************************
    localparam logic [31:0] MEM_BASE      = 32'h1000_0000;
    localparam int          MEM_SIZE_LOG2 = 12;
    localparam logic [31:0] IO_BASE       = 32'h0000_1000;
    localparam int          IO_SIZE_LOG2  = 8;
    localparam logic [1:0]  ADDR_INC      = 2'h1;
    localparam int          INIT_LAT_CLKS = 16;
    localparam logic [4:0]  LAT_RETRY     = 5'(INIT_LAT_CLKS - 1);
    localparam logic [4:0]  LAT_START     = 5'h01;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TURN = 3'b001,
        ST_DATA = 3'b010,
        ST_STOP = 3'b011,
        ST_REL  = 3'b100,
        ST_BUSY = 3'b101
    } state_type;

    function automatic logic inWindow(input logic [31:0] a, input logic [31:0] base,
                                      input int sz);
        return (a >> sz) == (base >> sz);
    endfunction : inWindow

    // an enabled byte below the addressed byte cannot be served
    function automatic logic ioBeBad(input logic [3:0] beN, input logic [1:0] low);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (i < int'(low) && !beN[i]) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction : ioBeBad

endpackage : pci_target_pkg

//--- pkg/decode_if.sv
// interface: address phase fields and decode results
`timescale 1ns/100ps
interface decode_if;
    logic [3:0]  cmd;
    logic [31:0] ad;
    logic        idsel;
    logic        claim;
    logic        isRead;
    logic        isIo;
    logic        isMem;
    logic        burstBad;

    modport decoder (input cmd, ad, idsel, output claim, isRead, isIo, isMem, burstBad);
    modport user    (output cmd, ad, idsel, input claim, isRead, isIo, isMem, burstBad);
endinterface : decode_if

//--- rtl/pci_cmd_decode.sv
// module: command and address decode of the address phase
`timescale 1ns/100ps
module pci_cmd_decode
    import pci_target_pkg::*;
(
    decode_if.decoder bus
);
    logic memHit;
    logic ioHit;

    assign memHit = inWindow(bus.ad, MEM_BASE, MEM_SIZE_LOG2);
    assign ioHit  = inWindow(bus.ad, IO_BASE, IO_SIZE_LOG2);

    always_comb begin
        bus.claim    = 1'b0;
        bus.isRead   = 1'b0;
        bus.isIo     = 1'b0;
        bus.isMem    = 1'b0;
        bus.burstBad = 1'b0;
        // only named commands reach a claim; all else falls to no claim
        unique case (bus.cmd)
            CMD_IO_RD, CMD_IO_WR: begin
                bus.claim  = ioHit;
                bus.isIo   = 1'b1;
                bus.isRead = (bus.cmd == CMD_IO_RD);
            end
            CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RDM, CMD_MEM_RDL, CMD_MEM_WRI: begin
                bus.claim    = memHit;
                bus.isMem    = 1'b1;
                bus.isRead   = (bus.cmd != CMD_MEM_WR) && (bus.cmd != CMD_MEM_WRI);
                bus.burstBad = (bus.ad[1:0] != 2'h0);
            end
            CMD_CFG_RD, CMD_CFG_WR: begin
                bus.claim  = bus.idsel && (bus.ad[1:0] == 2'h0);
                bus.isRead = (bus.cmd == CMD_CFG_RD);
            end
            default: begin
                bus.claim = 1'b0;
            end
        endcase
    end
endmodule : pci_cmd_decode

//--- rtl/pci_parity_unit.sv
// module: par generation and write data parity check
`timescale 1ns/100ps
module pci_parity_unit
    import pci_target_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [31:0] adDrv,
    input  wire logic        adDrvOe,
    input  wire logic [31:0] adIn,
    input  wire logic [3:0]  cbeIn,
    input  wire logic        parIn,
    input  wire logic        wrXfer,
    input  wire logic        perrEnable,
    output logic             parOut,
    output logic             parOeN,
    output logic             perrN,
    output logic             perrOeN
);
    typedef struct packed {
        logic par;
        logic parOe;
        logic pend;
        logic calc;
        logic perrAct;
        logic perrHi;
    } par_type;

    par_type p_r;
    par_type p_nxt;

    always_comb begin
        p_nxt       = p_r;
        p_nxt.par   = ^{adDrv, cbeIn};
        p_nxt.parOe = adDrvOe;              // par trails ad by one clock
        p_nxt.pend  = wrXfer;               // only claimed, completed phases
        p_nxt.calc  = ^{adIn, cbeIn};
        p_nxt.perrAct = p_r.pend && (p_r.calc ^ parIn) && perrEnable;
        p_nxt.perrHi  = p_r.perrAct && !p_nxt.perrAct; // high one clock first
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            p_r <= '0;
        end else begin
            p_r <= p_nxt;
        end
    end

    assign parOut  = p_r.par;
    assign parOeN  = ~p_r.parOe;
    assign perrN   = ~p_r.perrAct;
    assign perrOeN = ~(p_r.perrAct | p_r.perrHi);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_perr_cause;
        $fell(perrN) |-> $past(wrXfer, 2);
    endproperty
    a_perr_cause: assert property (p_perr_cause) else $error("perr without a write phase");

    property p_par_even;
        !parOeN |-> (parOut == ^{$past(adDrv), $past(cbeIn)});
    endproperty
    a_par_even: assert property (p_par_even) else $error("par parity wrong");
endmodule : pci_parity_unit

//--- rtl/pci_target_protocol.sv
// module: pci target bus protocol engine with a simple local side
`timescale 1ns/100ps
module pci_target_protocol
    import pci_target_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        frameN,
    input  wire logic        irdyN,
    input  wire logic        idsel,
    input  wire logic [31:0] adIn,
    input  wire logic [3:0]  cbeIn,
    input  wire logic        parIn,
    input  wire logic        perrEnable,
    output logic      [31:0] adOut,
    output logic             adOeN,
    output logic             parOut,
    output logic             parOeN,
    output logic             trdyN,
    output logic             trdyOeN,
    output logic             stopN,
    output logic             stopOeN,
    output logic             devselN,
    output logic             devselOeN,
    output logic             perrN,
    output logic             perrOeN,
    output logic      [31:0] locAddr,
    output logic             locIsIo,
    output logic             locRdReq,
    input  wire logic [31:0] locRdData,
    input  wire logic        locRdValid,
    input  wire logic        locWrReady,
    input  wire logic        locAbort,
    output logic             locWrStrobe,
    output logic      [31:0] locWrData,
    output logic      [3:0]  locWrBe,
    output logic      [31:0] locWrAddr
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        state_type   state;
        logic        frameQ;
        logic        devsel;
        logic        trdy;
        logic        stop;
        logic        drvCtl;
        logic        adOe;
        logic [31:0] adOut;
        logic [31:0] addr;
        logic [1:0]  ioLow;
        logic        isRead;
        logic        isIo;
        logic        disc;
        logic        first;
        logic [4:0]  latCnt;
        logic        dataRdy;
        logic        wrStb;
        logic [31:0] wrData;
        logic [3:0]  wrBe;
        logic [31:0] wrAddr;
    } regs_type;

    regs_type s_r;
    regs_type s_nxt;
    logic     xfer;
    logic     lastInWin;
    logic     wrXfer;

    decode_if dec();

    assign dec.cmd   = cbeIn;
    assign dec.ad    = adIn;
    assign dec.idsel = idsel;

    pci_cmd_decode u_decode (
        .bus (dec.decoder)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    assign xfer      = s_r.trdy && !irdyN;
    assign lastInWin = &s_r.addr[MEM_SIZE_LOG2-1:2];
    assign wrXfer    = xfer && !s_r.isRead && (s_r.state == ST_DATA);

    always_comb begin
        s_nxt        = s_r;
        s_nxt.frameQ = frameN;
        s_nxt.wrStb  = 1'b0;
        // lock is not looked at: exclusive sequences pass as plain ones
        unique case (s_r.state)
            ST_IDLE: begin
                s_nxt.drvCtl = 1'b0;
                if (s_r.frameQ && !frameN) begin
                    if (dec.claim) begin
                        s_nxt.state   = ST_TURN;
                        s_nxt.devsel  = 1'b1;
                        s_nxt.drvCtl  = 1'b1;
                        s_nxt.addr    = {adIn[31:2], 2'h0};
                        s_nxt.ioLow   = adIn[1:0];
                        s_nxt.isRead  = dec.isRead;
                        s_nxt.isIo    = dec.isIo;
                        // i/o and config are single word: disconnect after one
                        s_nxt.disc    = dec.burstBad || !dec.isMem;
                        s_nxt.first   = 1'b1;
                        s_nxt.latCnt  = LAT_START;
                        s_nxt.dataRdy = 1'b0;
                    end else begin
                        s_nxt.state = ST_BUSY;
                    end
                end
            end
            ST_TURN: begin
                // master still owns ad here, so no drive and no trdy
                s_nxt.state  = ST_DATA;
                s_nxt.latCnt = s_r.latCnt + 5'h01;
                s_nxt.adOe   = s_r.isRead;
            end
            ST_DATA: begin
                if (s_r.first) begin
                    s_nxt.latCnt = s_r.latCnt + 5'h01;
                end
                if (s_r.trdy) begin
                    if (xfer) begin
                        s_nxt.first   = 1'b0;
                        s_nxt.dataRdy = 1'b0;
                        s_nxt.addr    = s_r.addr + {28'h0, ADDR_INC, 2'h0};
                        s_nxt.wrStb   = !s_r.isRead;
                        s_nxt.wrData  = adIn;
                        s_nxt.wrBe    = cbeIn;
                        s_nxt.wrAddr  = s_r.addr;
                        if (frameN) begin
                            s_nxt.state  = ST_REL;
                            s_nxt.trdy   = 1'b0;
                            s_nxt.devsel = 1'b0;
                            s_nxt.adOe   = 1'b0;
                        end else if (s_r.disc || lastInWin) begin
                            s_nxt.state = ST_STOP;
                            s_nxt.trdy  = 1'b0;
                            s_nxt.stop  = 1'b1;
                        end else begin
                            s_nxt.trdy = !s_r.isRead && locWrReady;
                        end
                    end
                    // otherwise all three hold while irdy is awaited
                end else if (s_r.first && s_r.isIo
                             && (ioBeBad(cbeIn, s_r.ioLow) || locAbort)) begin
                    // trdy is already low here, abort drops devsel
                    s_nxt.state  = ST_STOP;
                    s_nxt.stop   = 1'b1;
                    s_nxt.devsel = 1'b0;
                end else if (s_r.first && s_r.latCnt >= LAT_RETRY) begin
                    s_nxt.state = ST_STOP;                          // retry
                    s_nxt.stop  = 1'b1;
                end else if (s_r.isRead) begin
                    // ad only loads while trdy is low, then stays
                    if (s_r.dataRdy) begin
                        s_nxt.trdy = 1'b1;
                    end else if (locRdValid) begin
                        s_nxt.adOut   = locRdData;
                        s_nxt.dataRdy = 1'b1;
                    end
                end else begin
                    s_nxt.trdy = locWrReady;
                end
            end
            ST_STOP: begin
                // stop is only released by frame high, never to go on
                if (frameN) begin
                    s_nxt.state  = ST_REL;
                    s_nxt.stop   = 1'b0;
                    s_nxt.devsel = 1'b0;
                    s_nxt.trdy   = 1'b0;
                    s_nxt.adOe   = 1'b0;
                end
            end
            ST_REL: begin
                s_nxt.state  = ST_IDLE;
                s_nxt.drvCtl = 1'b0;
            end
            ST_BUSY: begin
                if (frameN && irdyN) begin
                    s_nxt.state = ST_IDLE;
                end
            end
            default: begin
                s_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign adOut       = s_r.adOut;
    assign adOeN       = ~s_r.adOe;
    assign trdyN       = ~s_r.trdy;
    assign stopN       = ~s_r.stop;
    assign devselN     = ~s_r.devsel;
    assign trdyOeN     = ~s_r.drvCtl;
    assign stopOeN     = ~s_r.drvCtl;
    assign devselOeN   = ~s_r.drvCtl;
    assign locAddr     = s_r.addr;
    assign locIsIo     = s_r.isIo;
    assign locRdReq    = (s_r.state == ST_DATA) && s_r.isRead && !s_r.dataRdy;
    assign locWrStrobe = s_r.wrStb;
    assign locWrData   = s_r.wrData;
    assign locWrBe     = s_r.wrBe;
    assign locWrAddr   = s_r.wrAddr;

    pci_parity_unit u_parity (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .adDrv      (s_r.adOut),
        .adDrvOe    (s_r.adOe),
        .adIn       (adIn),
        .cbeIn      (cbeIn),
        .parIn      (parIn),
        .wrXfer     (wrXfer),
        .perrEnable (perrEnable),
        .parOut     (parOut),
        .parOeN     (parOeN),
        .perrN      (perrN),
        .perrOeN    (perrOeN)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    logic trdyAct;
    logic stopAct;
    logic devAct;
    assign trdyAct = !trdyN && !trdyOeN;
    assign stopAct = !stopN && !stopOeN;
    assign devAct  = !devselN && !devselOeN;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_drive_high;
        trdyN && stopN && devselN && !trdyOeN;
    endsequence
    sequence s_released;
        trdyOeN && stopOeN && devselOeN;
    endsequence

    property p_trdy_hold;
        (trdyAct && irdyN) |=> ($stable(trdyN) && $stable(stopN) && $stable(devselN));
    endproperty
    a_trdy_hold: assert property (p_trdy_hold) else $error("trdy phase moved");

    property p_stop_hold;
        (stopAct && !frameN) |=> (stopAct && $stable(trdyN) && $stable(devselN));
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop phase moved");

    property p_stop_end;
        (stopAct && frameN) |=> s_drive_high ##1 s_released;
    endproperty
    a_stop_end: assert property (p_stop_end) else $error("stop not ended");

    property p_last_end;
        (xfer && frameN) |=> s_drive_high ##1 s_released;
    endproperty
    a_last_end: assert property (p_last_end) else $error("bad end of last phase");

    property p_turn;
        (s_r.state == ST_TURN && s_r.isRead) |-> (trdyN && adOeN);
    endproperty
    a_turn: assert property (p_turn) else $error("trdy in turnaround");

    property p_latency;
        $rose(devAct) |-> ##[0:15] (trdyAct || stopAct);
    endproperty
    a_latency: assert property (p_latency) else $error("first phase too slow");

    property p_devsel_first;
        $rose(trdyAct || stopAct) |-> $past(devAct);
    endproperty
    a_devsel_first: assert property (p_devsel_first) else $error("devsel late");

    property p_abort;
        (stopAct && devselN) |-> $past(trdyN);
    endproperty
    a_abort: assert property (p_abort) else $error("abort with trdy");

    property p_ad_stable;
        (trdyAct && !adOeN) |-> $stable(adOut);
    endproperty
    a_ad_stable: assert property (p_ad_stable) else $error("ad moved");

    property p_par_lag;
        $fell(adOeN) |=> !parOeN;
    endproperty
    a_par_lag: assert property (p_par_lag) else $error("par late");

    property p_no_reserved;
        (s_r.state == ST_IDLE && s_r.frameQ && !frameN &&
         (cbeIn == CMD_SPECIAL || cbeIn == CMD_DUAL || cbeIn == CMD_INTACK))
        |=> (s_r.state == ST_BUSY);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved claimed");
endmodule : pci_target_protocol

//--- test/pci_master_model.sv
// partner: behavioural pci bus master facing the target
`timescale 1ns/100ps
module pci_master_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] adIn,
    input  wire logic [3:0]  cbeIn,
    input  wire logic        trdyN,
    input  wire logic        stopN,
    input  wire logic        devselN,
    output logic             frameN = 1'b1,
    output logic             irdyN  = 1'b1,
    output logic             idsel  = 1'b0,
    output logic      [31:0] mAd    = 32'h0,
    output logic      [3:0]  cbe    = 4'h0,
    output logic             mPar   = 1'b0
);
    // ****************************************************************
    // master side of one transaction
    // ****************************************************************
    logic        badPar = 1'b0;
    int          irdyWait = 0;
    logic [31:0] got[$];

    // par trails the lines by one clock; badPar spoils it on purpose
    always @(posedge sys_clk) begin
        mPar <= ^{adIn, cbeIn} ^ badPar;
    end

    task automatic run(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
                       input logic [3:0] be, input int n, input logic [31:0] wd,
                       output int words, output logic cl, output logic ab);
        logic last;
        logic xfer;
        words = 0;
        cl = 1'b0;
        ab = 1'b0;
        got.delete();
        @(posedge sys_clk);
        frameN <= 1'b0;
        cbe <= cmd;
        mAd <= a;
        idsel <= sel;
        @(posedge sys_clk);
        frameN <= n == 1;
        irdyN <= (irdyWait != 0);
        cbe <= be;
        idsel <= 1'b0;
        // a read hands ad to the target, so show the inverse, never the old value
        mAd <= cmd[0] ? wd : ~a;
        for (int k = 1; k < 64; k++) begin
            @(posedge sys_clk);
            last = frameN;
            xfer = !irdyN && !trdyN;
            cl |= !devselN;
            ab |= !stopN && devselN;
            if (xfer) begin
                words++;
            end
            if (xfer && !cmd[0]) begin
                got.push_back(adIn);
            end
            // silence after five clocks ends as a master abort
            if (last && (!stopN || xfer || k > 5 && !cl)) begin
                irdyN <= 1'b1;
                mAd <= ~mAd;
                cbe <= ~cbe;
                break;
            end
            // a late irdy makes an asserted trdy wait through its phase
            if (k == irdyWait) begin
                irdyN <= 1'b0;
            end
            if (xfer && cmd[0]) begin
                mAd <= wd + 32'(words);
            end
            if (!stopN || words == n - 1 || k > 4 && !cl) begin
                frameN <= 1'b1;
            end
        end
    endtask : run
endmodule : pci_master_model

//--- test/tb_top.sv
// testbench: pci target against a master model and a random local side
`timescale 1ns/100ps
module tb_top;
    import pci_target_pkg::*;
    // ****************************************************************
    // stimulus, local side, monitors
    // ****************************************************************
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        frameN, irdyN, idsel, mPar, parIn, adOeN, parOut, parOeN, trdyN, trdyOeN;
    logic        stopN, stopOeN, devselN, devselOeN, perrN, perrOeN, locIsIo, locRdReq;
    logic        locWrStrobe;
    logic [31:0] mAd, adIn, adOut, locAddr, locRdData, locWrData, locWrAddr, adQ, wBase, r, a;
    logic [3:0]  cbe, cbeQ, locWrBe, wBe;
    logic        locRdValid = 1'b0;
    logic        locWrReady = 1'b0;
    logic        locAbort = 1'b0;
    logic        perrEn = 1'b1;
    logic        wIo = 1'b0;
    int          seed = 30184;
    int          mode = 1;
    int          err_count = 0;
    int          n_tests = 0;
    int          wIdx = 0;
    int          perrCnt = 0;
    int          cyc = 0;
    int          n;
    logic [3:0]  cC [8] = '{CMD_MEM_WR, CMD_MEM_RD, CMD_MEM_RD, CMD_IO_RD, CMD_CFG_WR,
                            CMD_SPECIAL, CMD_DUAL, CMD_MEM_WR};
    logic [31:0] cA [8] = '{MEM_BASE + 32'hFF8, MEM_BASE + 32'hFF8, MEM_BASE + 32'h1,
                            IO_BASE + 32'h2, 32'h1, 32'h0, MEM_BASE, MEM_BASE};
    int          cN [8] = '{4, 4, 3, 1, 1, 1, 1, 2};
    int          cM [8] = '{1, 2, 1, 1, 1, 1, 1, 0};

    assign adIn = adOeN ? mAd : adOut;
    assign parIn = parOeN ? mPar : parOut;
    assign locRdData = locAddr ^ 32'h5A5A_5A5A;

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    pci_target_protocol pci_target_protocol_i (
        .sys_clk, .srst, .frameN, .irdyN, .idsel, .adIn, .cbeIn(cbe), .parIn,
        .perrEnable(perrEn), .adOut, .adOeN, .parOut, .parOeN, .trdyN, .trdyOeN, .stopN,
        .stopOeN, .devselN, .devselOeN, .perrN, .perrOeN, .locAddr, .locIsIo, .locRdReq,
        .locRdData, .locRdValid, .locWrReady, .locAbort, .locWrStrobe, .locWrData,
        .locWrBe, .locWrAddr);

    // released control lines float high through their pull-ups
    pci_master_model pci_master_model_i (
        .sys_clk, .adIn, .cbeIn(cbe), .trdyN(trdyN | trdyOeN), .stopN(stopN | stopOeN),
        .devselN(devselN | devselOeN), .frameN, .irdyN, .idsel, .mAd, .cbe, .mPar);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    always @(posedge sys_clk) begin
        locRdValid <= mode == 1 || mode == 2 && $random(seed) % 4 != 0;
        locWrReady <= mode == 1 || mode == 2 && $random(seed) % 4 != 0;
        adQ <= adIn;
        cbeQ <= cbe;
        cyc <= cyc + 1;
        if (perrN === 1'b0 && perrOeN === 1'b0) begin
            perrCnt <= perrCnt + 1;
        end
        if (parOeN === 1'b0) begin
            chk("par", 32'h0, 32'(^{adQ, cbeQ, parOut}));
        end
        if (locWrStrobe === 1'b1) begin
            chk("wr data", ~wBase + 32'(wIdx), locWrData);
            chk("wr addr", (wBase & 32'hFFFF_FFFC) + 32'(wIdx * 4), locWrAddr);
            chk("wr be", 32'(wBe), 32'(locWrBe));
            chk("wr io", 32'(wIo), 32'(locIsIo));
            wIdx <= wIdx + 1;
        end
        if (locRdReq === 1'b1) begin
            chk("rd req", 32'h1, 32'(trdyN && !devselN));
        end
        // ceiling well above 158 transactions of some 40 clocks
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic txn(input logic [3:0] cmd, input logic [31:0] ad, input logic sel,
                       input logic [3:0] be, input int nw, input int md, input logic bad);
        int          words, expW, p0;
        logic        cl, ab, io, hit, abt;
        logic [31:0] wa;
        io = cmd[3:1] == 3'h1;
        wa = ad & 32'hFFFF_FFFC;
        hit = (cmd[3:1] == 3'h3 || cmd[3:2] == 2'h3 && cmd != CMD_DUAL)
              && (ad >> MEM_SIZE_LOG2) == (MEM_BASE >> MEM_SIZE_LOG2)
              || io && (ad >> IO_SIZE_LOG2) == (IO_BASE >> IO_SIZE_LOG2)
              || cmd[3:1] == 3'h5 && sel && ad[1:0] == 2'h0;
        abt = hit && io && (bad || ad[1:0] > 2'h0 && !be[0] || ad[1:0] > 2'h1 && !be[1]
              || ad[1:0] > 2'h2 && !be[2]);
        expW = !hit || abt || md == 0 ? 0 : !io && cmd[3:1] != 3'h5 && ad[1:0] == 2'h0 ?
               ((1 << MEM_SIZE_LOG2) - int'(ad[MEM_SIZE_LOG2-1:0])) / 4 : 1;
        expW = expW > nw ? nw : expW;
        mode = md;
        locAbort <= bad && io;
        pci_master_model_i.badPar = bad;
        wBase = ad;
        wBe = be;
        wIo = io;
        wIdx = 0;
        p0 = perrCnt;
        pci_master_model_i.run(cmd, ad, sel, be, nw, ~ad, words, cl, ab);
        repeat (4) @(posedge sys_clk);
        chk("claim", 32'(hit), 32'(cl));
        chk("abort", 32'(abt), 32'(ab));
        chk("words", 32'(expW), 32'(words));
        chk("strobes", cmd[0] ? 32'(expW) : 32'h0, 32'(wIdx));
        chk("perr", 32'(bad && cmd[0] && expW > 0 && perrEn), 32'(perrCnt - p0));
        for (int i = 0; i < pci_master_model_i.got.size(); i++) begin
            chk("rd data", (wa + 32'(4 * i)) ^ 32'h5A5A_5A5A, pci_master_model_i.got[i]);
        end
    endtask : txn

    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        for (int t = 0; t < 8; t++) begin
            txn(cC[t], cA[t], 1'b1, 4'h0, cN[t], cM[t], 1'b0);
        end
        for (int t = 0; t < 150; t++) begin
            r = $random(seed);
            n = 1 + int'(r[9:8]);
            perrEn <= r[20];
            pci_master_model_i.irdyWait = int'(r[19:18]);
            a = r[31] ? (r[30] ? MEM_BASE | 32'hFE0 | (r & 32'h1F) : IO_BASE | (r & 32'hFF))
                : r & 32'h3000_00FF;
            txn(r[7:4], a, r[10], r[15:12], n, r[17:16] == 2'h0 ? 0 : 1 + int'(r[16]),
                n == 1 && r[11]);
        end
        results();
    end
endmodule : tb_top
